/* File: verilog/io_bridge_params.svh */
// constants for the i/o register access bridge
// assumes one system clock; target clocks arrive as enable ticks
`ifndef IO_BRIDGE_PARAMS_SVH
`define IO_BRIDGE_PARAMS_SVH
`define MAIN_BUS_CYCLES 4'h1
`define BUS_SEL_W 3
`define BUS_NONE 3'h0
`define BUS_PERIPH1 3'h1
`define BUS_PERIPH6 3'h6
`define BUS_EXTCTRL 3'h7
`define CLK_PERIOD_NS 10
`endif

/* File: verilog/io_bridge_pkg.sv */
// types shared by the i/o register access bridge
// assumes the params header sits beside it
package io_bridge_pkg;
    typedef enum logic [2:0] {
        IDLE, MAINBUS, SYNC, PERIPH, DONE
    } bridge_state_t;
    typedef logic [3:0] cycle_count_t;
endpackage

/* File: verilog/sync_edge_wait.sv */
// waits for the next target clock tick before a peripheral access
// assumes targetTick is a one-cycle pulse in the system clock domain
`timescale 1ns/1ps
`default_nettype none
module sync_edge_wait
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic targetTick,
    output logic aligned
);
    logic waiting;
    logic next_waiting;

    always_comb begin
        next_waiting = waiting;
        if (start && !targetTick) begin
            next_waiting = 1'b1;
        end else if (targetTick) begin
            next_waiting = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            waiting <= 1'b0;
        end else begin
            waiting <= next_waiting;
        end
    end

    // slack depends on where the access falls against the tick
    assign aligned = (start || waiting) && targetTick; // RULE4
endmodule
`default_nettype wire

/* File: verilog/io_register_access_timing_bridge.sv */
// cpu to peripheral register bridge with cycle-accurate stalling
// assumes target clocks are given as ticks of ref_clk, ratio >= 1
`timescale 1ns/1ps
`default_nettype none
`include "io_bridge_params.svh"
// Function
// RULE1: access time is main-bus cycles plus sync cycles plus peripheral-bus cycles.
// RULE2: the peripheral-bus share comes per register from the busCycles input.
// RULE3: sync is added only for buses two to six and bus-control registers, not bus-error ones.
// RULE4: sync length follows the clock ratio and where the access falls against target ticks.
// RULE5: with a faster system clock, main-bus plus sync fit inside one target period.
// RULE6: that one target period is budgeted on top of the per-register count.
// RULE7: with a slower system clock, the next access starts the cycle after completion.
// RULE8: bus-control registers budget one external-bus clock period for main-bus plus sync.
// RULE9: counts hold only with no contention from other masters or external fetches.
// RULE10: software reads back only the last written register to ensure completion.
// RULE11: the cpu is stalled until the peripheral access ends, then gets data or an ack.
module io_register_access_timing_bridge
    import io_bridge_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 24
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // cpu side
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic [ADDR_W-1:0] cpuAddr,
    input wire logic [DATA_W-1:0] cpuWdata,
    input wire logic [`BUS_SEL_W-1:0] busSel,
    input wire logic busErrorReg,
    input wire logic [3:0] busCycles,
    input wire logic systemSlower,
    output logic cpuReady,
    output logic [DATA_W-1:0] cpuRdata,
    output logic [5:0] lastAccessCycles,
    // contention from other masters
    input wire logic otherMasterBusy,
    // target clock ticks
    input wire logic periphTick,
    input wire logic extBusTick,
    // peripheral side
    output logic periphReq,
    output logic periphWrite,
    output logic [`BUS_SEL_W-1:0] periphBus,
    output logic [ADDR_W-1:0] periphAddr,
    output logic [DATA_W-1:0] periphWdata,
    input wire logic [DATA_W-1:0] periphRdata
);
    // ---------------------------------------------------------------
    // state and datapath
    // ---------------------------------------------------------------
    bridge_state_t state, next_state;
    cycle_count_t count, next_count;
    logic [5:0] total, next_total;
    logic [DATA_W-1:0] next_cpuRdata;
    logic [`BUS_SEL_W-1:0] next_periphBus;
    logic [ADDR_W-1:0] next_periphAddr;
    logic [DATA_W-1:0] next_periphWdata;
    logic next_periphWrite;
    logic needSync;
    logic syncStart;
    logic aligned;
    logic targetTick;
    logic takeReq;
    logic lastPeriph;

    // ---------------------------------------------------------------
    // counting helpers
    // ---------------------------------------------------------------
    // total saturates so a tick that never comes cannot wrap the figure
    function automatic logic [5:0] add_cycle(input logic [5:0] cur);
        add_cycle = (cur == 6'h3F) ? cur : cur + 6'h01;
    endfunction

    function automatic logic at_last(input cycle_count_t cur);
        at_last = (cur <= 4'h1);
    endfunction

    // a zero per-register figure still costs one peripheral-bus cycle
    function automatic cycle_count_t periph_load(input logic [3:0] cycles);
        periph_load = (cycles == 4'h0) ? 4'h1 : cycles;
    endfunction

    // ---------------------------------------------------------------
    // sync decision
    // ---------------------------------------------------------------
    function automatic logic sync_needed(input logic [`BUS_SEL_W-1:0] sel, input logic berr);
        sync_needed = !berr && ((sel > `BUS_PERIPH1 && sel <= `BUS_PERIPH6)
                      || sel == `BUS_EXTCTRL); // RULE3
    endfunction

    assign needSync = sync_needed(periphBus, busErrorReg);
    // bus-control side waits on external-bus ticks
    assign targetTick = (periphBus == `BUS_EXTCTRL) ? extBusTick : periphTick; // RULE8
    assign syncStart = (state == MAINBUS) && needSync && !systemSlower;

    sync_edge_wait u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(syncStart),
        .targetTick(targetTick),
        .aligned(aligned)
    );

    // ---------------------------------------------------------------
    // access sequencer
    // ---------------------------------------------------------------
    assign takeReq = (state == IDLE) && cpuReq && !otherMasterBusy;
    assign lastPeriph = (state == PERIPH) && at_last(count);

    always_comb begin
        next_state = state;
        next_count = count;
        next_total = total;
        unique case (state)
            IDLE: begin
                // other masters hold the bus; the fixed counts do not apply then
                if (takeReq) begin // RULE9
                    next_state = MAINBUS;
                    next_count = `MAIN_BUS_CYCLES;
                    next_total = 6'h00;
                end
            end
            MAINBUS: begin
                next_total = add_cycle(total); // RULE1
                if (at_last(count)) begin
                    // main bus and sync overlap inside one target period
                    if (needSync && !systemSlower) begin // RULE5
                        next_state = aligned ? PERIPH : SYNC; // RULE6
                    end else begin
                        next_state = PERIPH;
                    end
                    next_count = periph_load(busCycles); // RULE2
                end else begin
                    next_count = count - 4'h1;
                end
            end
            SYNC: begin
                next_total = add_cycle(total); // RULE1
                if (aligned) begin
                    next_state = PERIPH;
                end
            end
            PERIPH: begin
                next_total = add_cycle(total); // RULE1
                if (lastPeriph) begin
                    next_state = DONE;
                end else begin
                    next_count = count - 4'h1;
                end
            end
            DONE: begin
                // next access may begin on the following cycle
                next_state = IDLE; // RULE7
            end
        endcase
    end

    // ---------------------------------------------------------------
    // sequencer registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= IDLE;
            count <= 4'h0;
            total <= 6'h00;
        end else begin
            state <= next_state;
            count <= next_count;
            total <= next_total;
        end
    end

    // ---------------------------------------------------------------
    // request capture and read data
    // ---------------------------------------------------------------
    // fields held from the take edge until the next request
    always_comb begin
        next_periphBus = periphBus;
        next_periphAddr = periphAddr;
        next_periphWdata = periphWdata;
        next_periphWrite = periphWrite;
        next_cpuRdata = cpuRdata;
        if (takeReq) begin
            next_periphBus = busSel;
            next_periphAddr = cpuAddr;
            next_periphWdata = cpuWdata;
            next_periphWrite = cpuWrite;
        end
        // read data caught on the last peripheral-bus cycle only
        if (lastPeriph && !periphWrite) begin // RULE11
            next_cpuRdata = periphRdata;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cpuRdata <= '0;
            periphBus <= `BUS_NONE;
            periphAddr <= '0;
            periphWdata <= '0;
            periphWrite <= 1'b0;
        end else begin
            cpuRdata <= next_cpuRdata;
            periphBus <= next_periphBus;
            periphAddr <= next_periphAddr;
            periphWdata <= next_periphWdata;
            periphWrite <= next_periphWrite;
        end
    end

    // ---------------------------------------------------------------
    // handshake outputs
    // ---------------------------------------------------------------
    // cpu stalls until completion, then one ready pulse
    assign cpuReady = (state == DONE); // RULE11
    assign periphReq = (state == PERIPH);
    assign lastAccessCycles = total;
endmodule
`default_nettype wire

/* File: testbench/periph_model.sv */
// register model for the far side of the bridge
// assumes periphReq qualifies address and data for a whole access
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input wire logic ref_clk,
    input wire logic periphReq,
    input wire logic periphWrite,
    input wire logic [23:0] periphAddr,
    input wire logic [31:0] periphWdata,
    output logic [31:0] periphRdata
);
    logic [31:0] mem [16];
    logic [31:0] last = 32'h00000000;
    always @(posedge ref_clk) begin
        if (periphReq && periphWrite) mem[periphAddr[3:0]] <= periphWdata;
        if (periphReq) last <= mem[periphAddr[3:0]];
    end
    // released bus shows the inverse so a stale word never matches
    assign periphRdata = (periphReq && !periphWrite) ? mem[periphAddr[3:0]] : ~last;
endmodule
`default_nettype wire

/* File: testbench/bridge_sva.sv */
// timing checker for the register access bridge
// assumes busSel, busCycles and cpuAddr are held for a whole access
`timescale 1ns/1ps
`default_nettype none
module bridge_sva #(parameter int DATA_W = 32, parameter int ADDR_W = 24) (
    input wire logic ref_clk, reset, cpuReq, busErrorReg, systemSlower, otherMasterBusy,
    input wire logic periphTick, extBusTick, cpuReady, periphReq, periphWrite,
    input wire logic [2:0] busSel,
    input wire logic [3:0] busCycles,
    input wire logic [5:0] lastAccessCycles,
    input wire logic [ADDR_W-1:0] cpuAddr, periphAddr,
    input wire logic [DATA_W-1:0] cpuRdata, periphRdata
);
    logic busy;
    logic [5:0] acc, hi;
    wire logic take = !busy && cpuReq && !otherMasterBusy;
    wire logic noSync = busSel <= 3'h1 || busErrorReg || systemSlower;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            acc <= 6'h00;
            hi <= 6'h00;
        end else begin
            busy <= take || (busy && !cpuReady);
            acc <= take ? 6'h00 : acc + 6'h01;
            hi <= periphReq ? hi + 6'h01 : 6'h00;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_mainPeriph;
        !periphReq ##1 periphReq;
    endsequence
    chk_ready_pulse: assert property (cpuReady |=> !cpuReady)
        else $error("ready held too long");
    chk_periph_len: assert property ($fell(periphReq) |-> cpuReady &&
        hi == ((busCycles == 4'h0) ? 6'h01 : {2'h0, busCycles})) else $error("bad bus length");
    chk_total_count: assert property (cpuReady |=> lastAccessCycles == $past(acc))
        else $error("bad cycle total");
    chk_no_sync: assert property (take && noSync |=> s_mainPeriph)
        else $error("sync added");
    chk_sync_tick: assert property ($rose(periphReq) && !noSync |->
        $past(busSel == 3'h7 ? extBusTick : periphTick)) else $error("sync not on tick");
    chk_master_block: assert property (!busy && cpuReq && otherMasterBusy |-> ##2 !periphReq)
        else $error("started while blocked");
    chk_addr_pass: assert property ($rose(periphReq) |-> periphAddr == cpuAddr)
        else $error("bad address");
    chk_read_data: assert property (cpuReady && !periphWrite |-> cpuRdata == $past(periphRdata))
        else $error("bad read data");
endmodule
bind io_register_access_timing_bridge bridge_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
    bridge_sva_i (
        .ref_clk(ref_clk), .reset(reset), .cpuReq(cpuReq), .busErrorReg(busErrorReg),
        .systemSlower(systemSlower), .otherMasterBusy(otherMasterBusy),
        .periphTick(periphTick), .extBusTick(extBusTick), .cpuReady(cpuReady),
        .periphReq(periphReq), .periphWrite(periphWrite), .busSel(busSel),
        .busCycles(busCycles), .lastAccessCycles(lastAccessCycles), .cpuAddr(cpuAddr),
        .periphAddr(periphAddr), .cpuRdata(cpuRdata), .periphRdata(periphRdata)
    );
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the register access bridge
// assumes the peripheral model answers every bus at the far side
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0, reset = 1'b1, cpuReq = 1'b0, cpuWrite = 1'b0, busErrorReg = 1'b0;
    logic systemSlower = 1'b0, otherMasterBusy = 1'b0, periphTick = 1'b0, extBusTick = 1'b0;
    logic cpuReady, periphReq, periphWrite;
    logic [2:0] busSel = 3'h0, periphBus;
    logic [3:0] busCycles = 4'h1;
    logic [5:0] lastAccessCycles;
    logic [23:0] cpuAddr = 24'h000000, periphAddr;
    logic [31:0] cpuWdata = 32'h00000000, cpuRdata, periphWdata, periphRdata;
    int errors = 0, compares = 0, tc = 0;
    io_register_access_timing_bridge io_register_access_timing_bridge_i (
        .ref_clk(ref_clk), .reset(reset), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
        .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .busSel(busSel), .busErrorReg(busErrorReg),
        .busCycles(busCycles), .systemSlower(systemSlower), .cpuReady(cpuReady),
        .cpuRdata(cpuRdata), .lastAccessCycles(lastAccessCycles),
        .otherMasterBusy(otherMasterBusy), .periphTick(periphTick), .extBusTick(extBusTick),
        .periphReq(periphReq), .periphWrite(periphWrite), .periphBus(periphBus),
        .periphAddr(periphAddr), .periphWdata(periphWdata), .periphRdata(periphRdata)
    );
    periph_model periph_model_i (
        .ref_clk(ref_clk), .periphReq(periphReq), .periphWrite(periphWrite),
        .periphAddr(periphAddr), .periphWdata(periphWdata), .periphRdata(periphRdata)
    );
    initial forever #5 ref_clk = ~ref_clk;
    // target ticks every 4 and 6 cycles, so sync waits vary with phase
    always @(posedge ref_clk) begin
        #1;
        tc++;
        periphTick = tc % 4 == 0;
        extBusTick = tc % 6 == 0;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // write d, read it back, return the cycle count of the read
    task automatic acc(input logic [2:0] s, input logic b, input logic [3:0] n,
                       input logic [31:0] d, output logic [5:0] lc);
        int k;
        for (int r = 0; r < 2; r++) begin
            {cpuWrite, busSel, busErrorReg, busCycles} = {r == 0, s, b, n};
            cpuAddr = {21'h0, s};
            cpuWdata = d;
            cpuReq = 1'b1;
            k = 0;
            do begin @(posedge ref_clk); #1; k++; end while (cpuReady !== 1'b1 && k < 40);
            if (k >= 40) errors++;
            chk(periphBus, s);
            if (r == 1) chk(cpuRdata, d);
            cpuReq = 1'b0;
            @(posedge ref_clk);
            #1;
        end
        lc = lastAccessCycles;
    endtask
    task automatic t_no_sync;
        logic [5:0] lc;
        logic [2:0] bs [3] = '{3'h1, 3'h7, 3'h3};
        for (int i = 0; i < 3; i++) begin
            systemSlower = i == 2;
            acc(bs[i], i == 1, 4'(i * 3), 32'hA5A50000 + i, lc);
            chk(lc, (i == 0) ? 2 : 3 * i + 1);
        end
        systemSlower = 1'b0;
        $display("no-sync test done");
    endtask
    task automatic t_sync;
        logic [5:0] lc;
        for (int s = 2; s < 8; s++) begin
            acc(3'(s), 1'b0, 4'(s), 32'h12340000 + s, lc);
            chk(lc >= 6'(s + 1) && lc <= 6'(s + ((s == 7) ? 6 : 4)), 1'b1);
        end
        $display("sync test done");
    endtask
    task automatic t_blocked;
        otherMasterBusy = 1'b1;
        busSel = 3'h1;
        cpuReq = 1'b1;
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            chk(periphReq, 1'b0);
        end
        cpuReq = 1'b0;
        otherMasterBusy = 1'b0;
        @(posedge ref_clk);
        #1;
        $display("blocked test done");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_blocked();
        t_no_sync();
        t_sync();
        finish_test();
    end
    initial begin
        #100000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
